/* common/dbgu_pkg.sv */
// Purpose: constants for the debug uart register block
// Assumes: apb slave, 32-bit words, byte addresses as printed
// Notes:   status and mask registers share one bit layout
package dbgu_pkg;
  // register byte offsets
  localparam logic [11:0] OFS_CTRL   = 12'h000;
  localparam logic [11:0] OFS_MODE   = 12'h004;
  localparam logic [11:0] OFS_IEN    = 12'h008;
  localparam logic [11:0] OFS_IDIS   = 12'h00C;
  localparam logic [11:0] OFS_IMASK  = 12'h010;
  localparam logic [11:0] OFS_STAT   = 12'h014;
  localparam logic [11:0] OFS_RXH    = 12'h018;
  localparam logic [11:0] OFS_TXH    = 12'h01C;
  localparam logic [11:0] OFS_BAUD   = 12'h020;
  localparam logic [11:0] OFS_CID    = 12'h040;
  localparam logic [11:0] OFS_CIDX   = 12'h044;
  localparam logic [11:0] OFS_TAPRST = 12'h048;
  // control bits
  localparam int CB_RXRST = 2;
  localparam int CB_TXRST = 3;
  localparam int CB_RX_ENABLE_CMD  = 4;
  localparam int CB_RX_DISABLE_CMD = 5;
  localparam int CB_TX_ENABLE_CMD  = 6;
  localparam int CB_TX_DISABLE_CMD = 7;
  localparam int CB_STCLR = 8;
  // mode fields
  localparam int MF_PAR_LO = 9;
  localparam int MF_CHM_LO = 14;
  localparam logic [31:0] MODE_WMASK = 32'h0000CE00;
  // status / mask bits
  localparam int SB_RX_READY = 0;
  localparam int SB_TX_READY = 1;
  localparam int SB_RXEND = 3;
  localparam int SB_TXEND = 4;
  localparam int SB_OVR   = 5;
  localparam int SB_FRM   = 6;
  localparam int SB_PAR   = 7;
  localparam int SB_TXEMP = 9;
  localparam int SB_TXBE  = 11;
  localparam int SB_RXBF  = 12;
  localparam int SB_DBGW  = 30;
  localparam int SB_DBGR  = 31;
  localparam logic [31:0] IRQ_WMASK = 32'hC0001AFB;
  // reset values
  localparam logic [31:0] RST_MODE  = 32'h00000000;
  localparam logic [31:0] RST_MASK  = 32'h00000000;
  localparam logic [15:0] RST_BAUD  = 16'h0000;
  // identity words, values arbitrary
  localparam logic [31:0] CHIP_ID_VAL  = 32'h12345670;
  localparam logic [31:0] CHIP_EXT_VAL = 32'h00000000;
  // parity codes
  localparam logic [2:0] PAR_EVEN  = 3'h0;
  localparam logic [2:0] PAR_ODD   = 3'h1;
  localparam logic [2:0] PAR_SPACE = 3'h2;
  localparam logic [2:0] PAR_MARK  = 3'h3;
  // channel modes
  localparam logic [1:0] CHM_NORMAL = 2'h0;
  localparam logic [1:0] CHM_ECHO   = 2'h1;
  localparam logic [1:0] CHM_LLOOP  = 2'h2;
  localparam logic [1:0] CHM_RLOOP  = 2'h3;
  // oversampling points and data bit count
  localparam logic [3:0] OVS_LAST = 4'hF;
  localparam logic [3:0] OVS_MID  = 4'h7;
  localparam logic [3:0] DATA_BITS = 4'h8;
endpackage

/* hdl/dbgu_uart.sv */
// Functional notes
// R1: rx reset command resets and disables receiver at once, aborting frame
// R2: tx reset command resets and disables transmitter at once
// R3: rx enable acts only when rx disable is zero in same write
// R4: rx disable lets a character in reception finish first
// R5: tx enable acts only when tx disable is zero in same write
// R6: tx disable finishes shifted and held characters before stopping
// R7: status clear command clears parity, framing and overrun flags
// R8: parity field: even, odd, space, mark, none when top bit set
// R9: enable-set write ones set mask bits
// R10: enable-clear write ones clear mask bits
// R11: mask register reads enabled sources, resets to zero
// R12: status and mask share one bit layout
// R13: rx ready set on received character, cleared by read or disable
// R14: tx ready low while holding char waits or tx disabled
// R15: error flags sticky until status clear
// R16: tx idle only when holding and shifter empty and enabled
// R17: dma end bits mirror dma end inputs
// R18: dma buffer bits mirror dma buffer inputs
// R19: debug bits mirror debug channel inputs
// R20: baud divisor read/write at 0x20, resets to zero
// R21: divisor 0 off, 1 master clock, else clock over sixteen times divisor
// R22: frame: low start, eight data lsb first, optional parity, high stop
// R23: character done while rx ready set raises overrun
// R24: local loopback feeds tx to rx, pin ignored, out pin high
// R25: channel mode selects normal, echo, local and remote loopback
// R26: interrupt high when any status bit and its mask bit are set
//
// Purpose: debug uart with apb register file
// Assumes: apb inputs synchronous to clk_sys, no wait states
// Notes:   divisor 1 means one sample tick per clock, 16 ticks per bit
//
// Implementation choice: the APB register port.
`timescale 1ns/1ps
module dbgu_uart
  import dbgu_pkg::*;
(
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rstn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // side signals from dma and debug channel
  input  wire logic        rx_dma_end,
  input  wire logic        tx_dma_end,
  input  wire logic        tx_dma_buf_empty,
  input  wire logic        rx_dma_buf_full,
  input  wire logic        debug_write_pending,
  input  wire logic        debug_read_pending,
  // serial line and interrupt
  input  wire logic        serial_in_pin,
  output logic             serial_out_pin,
  output logic             irq
);

  typedef enum logic [3:0] {
    DU_IDLE  = 4'b0001,
    DU_DATA  = 4'b0010,
    DU_PAR   = 4'b0100,
    DU_STOP  = 4'b1000
  } du_st_e;

  function automatic logic parity_of(input logic [7:0] d,
                                     input logic [2:0] p);
    case (p)
      PAR_EVEN:  parity_of = ^d;
      PAR_ODD:   parity_of = ~(^d);
      PAR_SPACE: parity_of = 1'b0;
      default:   parity_of = 1'b1;
    endcase
  endfunction

  // apb decode; no wait states, unmapped reads zero with no error
  logic wr_en;
  logic rd_en;
  assign wr_en   = psel & penable & pwrite;
  assign rd_en   = psel & penable & ~pwrite;
  assign pready  = 1'b1;
  assign pslverr = 1'b0;

  logic cmd_wr;
  logic thr_wr;
  assign cmd_wr = wr_en && paddr == OFS_CTRL;
  assign thr_wr = wr_en && paddr == OFS_TXH;

  // register state
  logic [31:0] mode_q, mode_d;
  logic [31:0] mask_q, mask_d;
  logic [15:0] baud_q, baud_d;
  logic        tap_q, tap_d;
  logic [31:0] prdata_q, prdata_d;
  logic [31:0] status;
  logic [2:0]  par_sel;
  logic [1:0]  chm;
  assign par_sel = mode_q[MF_PAR_LO +: 3];
  assign chm     = mode_q[MF_CHM_LO +: 2];

  // baud tick: sixteen ticks per bit
  logic [15:0] bdiv_q, bdiv_d;
  logic        tick;
  always_comb begin
    bdiv_d = 16'h0000;
    tick   = 1'b0;
    if (baud_q == 16'h0001) begin
      tick = 1'b1; // R21
    end else if (baud_q != 16'h0000) begin
      tick   = (bdiv_q == 16'h0000); // R21
      bdiv_d = tick ? baud_q - 16'h0001 : bdiv_q - 16'h0001;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (!rstn) bdiv_q <= 16'h0000;
    else       bdiv_q <= bdiv_d;
  end

  // transmitter
  du_st_e     tst_q, tst_d;
  logic [3:0] tsub_q, tsub_d;
  logic [3:0] tcnt_q, tcnt_d;
  logic [7:0] tsh_q, tsh_d;
  logic [7:0] thr_q, thr_d;
  logic       thr_full_q, thr_full_d;
  logic       tx_en_q, tx_en_d;
  logic       tx_stop_q, tx_stop_d;
  logic       tline_q, tline_d;
  logic       tx_busy;
  assign tx_busy = (tst_q != DU_IDLE);

  always_comb begin
    tst_d = tst_q;  tsub_d = tsub_q;  tcnt_d = tcnt_q;
    tsh_d = tsh_q;  thr_d = thr_q;    thr_full_d = thr_full_q;
    tx_en_d = tx_en_q;  tx_stop_d = tx_stop_q;  tline_d = tline_q;
    if (thr_wr && tx_en_q) begin
      thr_d      = pwdata[7:0];
      thr_full_d = 1'b1;
    end
    if (tick) begin
      case (tst_q)
        DU_IDLE: begin
          if (thr_full_q && tx_en_q) begin
            tsh_d = thr_q;
            thr_full_d = thr_wr;
            tline_d = 1'b0; // R22
            tsub_d = 4'h0;
            tcnt_d = 4'h0;
            tst_d = DU_DATA;
          end
        end
        DU_DATA: begin
          tsub_d = tsub_q + 4'h1;
          if (tsub_q == OVS_LAST) begin
            if (tcnt_q == DATA_BITS) begin
              tline_d = par_sel[2] ? 1'b1 : parity_of(tsh_q, par_sel); // R8
              tst_d   = par_sel[2] ? DU_STOP : DU_PAR;
            end else begin
              tline_d = tsh_q[tcnt_q[2:0]]; // R22
              tcnt_d  = tcnt_q + 4'h1;
            end
          end
        end
        DU_PAR: begin
          tsub_d = tsub_q + 4'h1;
          if (tsub_q == OVS_LAST) begin
            tline_d = 1'b1;
            tst_d   = DU_STOP;
          end
        end
        DU_STOP: begin
          tsub_d = tsub_q + 4'h1;
          if (tsub_q == OVS_LAST) tst_d = DU_IDLE;
        end
        default: tst_d = DU_IDLE;
      endcase
    end
    // pending disable takes effect once nothing is left to send
    if (tx_stop_q && !tx_busy && !thr_full_q) begin
      tx_en_d = 1'b0; // R6
      tx_stop_d = 1'b0;
    end
    if (cmd_wr) begin
      if (pwdata[CB_TX_DISABLE_CMD]) tx_stop_d = tx_en_q; // R6
      else if (pwdata[CB_TX_ENABLE_CMD]) begin
        tx_en_d = 1'b1; // R5
        tx_stop_d = 1'b0;
      end
      if (pwdata[CB_TXRST]) begin
        tst_d = DU_IDLE; // R2
        thr_full_d = 1'b0;
        tx_en_d = 1'b0;
        tx_stop_d = 1'b0;
        tline_d = 1'b1;
      end
    end
  end
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      tst_q <= DU_IDLE;  tsub_q <= 4'h0;  tcnt_q <= 4'h0;
      tsh_q <= 8'h00;    thr_q <= 8'h00;  thr_full_q <= 1'b0;
      tx_en_q <= 1'b0;   tx_stop_q <= 1'b0;  tline_q <= 1'b1;
    end else begin
      tst_q <= tst_d;  tsub_q <= tsub_d;  tcnt_q <= tcnt_d;
      tsh_q <= tsh_d;  thr_q <= thr_d;    thr_full_q <= thr_full_d;
      tx_en_q <= tx_en_d;  tx_stop_q <= tx_stop_d;  tline_q <= tline_d;
    end
  end

  // channel mode routing
  logic rx_line;
  always_comb begin
    rx_line = serial_in_pin;
    serial_out_pin = tline_q;
    case (chm)
      CHM_ECHO:  serial_out_pin = serial_in_pin; // R25
      CHM_LLOOP: begin
        rx_line = tline_q; // R24
        serial_out_pin = 1'b1; // R24
      end
      CHM_RLOOP: begin
        rx_line = 1'b1; // R25
        serial_out_pin = serial_in_pin;
      end
      default: rx_line = serial_in_pin;
    endcase
  end

  // receiver
  du_st_e     rst_q, rst_d;
  logic [3:0] rsub_q, rsub_d;
  logic [3:0] rcnt_q, rcnt_d;
  logic [7:0] rsh_q, rsh_d;
  logic [7:0] rhr_q, rhr_d;
  logic       rx_rdy_q, rx_rdy_d;
  logic       rx_en_q, rx_en_d;
  logic       rx_stop_q, rx_stop_d;
  logic       rpar_q, rpar_d;
  logic       ovr_q, ovr_d, frm_q, frm_d, perr_q, perr_d;
  logic       rhr_rd;
  assign rhr_rd = rd_en && paddr == OFS_RXH;

  always_comb begin
    rst_d = rst_q;  rsub_d = rsub_q;  rcnt_d = rcnt_q;
    rsh_d = rsh_q;  rhr_d = rhr_q;    rx_rdy_d = rx_rdy_q;
    rx_en_d = rx_en_q;  rx_stop_d = rx_stop_q;  rpar_d = rpar_q;
    ovr_d = ovr_q;  frm_d = frm_q;  perr_d = perr_q;
    if (rhr_rd) rx_rdy_d = 1'b0; // R13
    if (cmd_wr && pwdata[CB_STCLR]) begin
      ovr_d = 1'b0; // R7
      frm_d = 1'b0;
      perr_d = 1'b0;
    end
    if (tick && rx_en_q) begin
      case (rst_q)
        DU_IDLE: begin
          rsub_d = 4'h0;
          rcnt_d = 4'h0;
          if (!rx_line && !rx_stop_q) rst_d = DU_DATA;
        end
        DU_DATA: begin
          rsub_d = rsub_q + 4'h1;
          if (rsub_q == OVS_MID) begin
            if (rcnt_q == 4'h0 && rx_line) rst_d = DU_IDLE; // false start
            else if (rcnt_q != 4'h0) rsh_d = {rx_line, rsh_q[7:1]}; // R22
            if (rcnt_q == DATA_BITS) rst_d = par_sel[2] ? DU_STOP : DU_PAR;
            rcnt_d = rcnt_q + 4'h1;
          end
        end
        DU_PAR: begin
          rsub_d = rsub_q + 4'h1;
          if (rsub_q == OVS_MID) begin
            rpar_d = rx_line;
            rst_d = DU_STOP;
          end
        end
        DU_STOP: begin
          rsub_d = rsub_q + 4'h1;
          if (rsub_q == OVS_MID) begin
            rhr_d = rsh_q;
            rx_rdy_d = 1'b1; // R13
            if (rx_rdy_q && !rhr_rd) ovr_d = 1'b1; // R23 R15
            if (!rx_line) frm_d = 1'b1; // R15
            if (!par_sel[2] && rpar_q != parity_of(rsh_q, par_sel))
              perr_d = 1'b1; // R8 R15
            rst_d = DU_IDLE;
          end
        end
        default: rst_d = DU_IDLE;
      endcase
    end
    if (rx_stop_q && rst_q == DU_IDLE) begin
      rx_en_d = 1'b0; // R4
      rx_stop_d = 1'b0;
      rx_rdy_d = 1'b0; // R13
    end
    if (cmd_wr) begin
      if (pwdata[CB_RX_DISABLE_CMD]) rx_stop_d = rx_en_q; // R4
      else if (pwdata[CB_RX_ENABLE_CMD]) begin
        rx_en_d = 1'b1; // R3
        rx_stop_d = 1'b0;
      end
      if (pwdata[CB_RXRST]) begin
        rst_d = DU_IDLE; // R1
        rx_en_d = 1'b0;
        rx_stop_d = 1'b0;
        rx_rdy_d = 1'b0;
      end
    end
  end
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      rst_q <= DU_IDLE;  rsub_q <= 4'h0;  rcnt_q <= 4'h0;
      rsh_q <= 8'h00;    rhr_q <= 8'h00;  rx_rdy_q <= 1'b0;
      rx_en_q <= 1'b0;   rx_stop_q <= 1'b0;  rpar_q <= 1'b0;
      ovr_q <= 1'b0;     frm_q <= 1'b0;   perr_q <= 1'b0;
    end else begin
      rst_q <= rst_d;  rsub_q <= rsub_d;  rcnt_q <= rcnt_d;
      rsh_q <= rsh_d;  rhr_q <= rhr_d;    rx_rdy_q <= rx_rdy_d;
      rx_en_q <= rx_en_d;  rx_stop_q <= rx_stop_d;  rpar_q <= rpar_d;
      ovr_q <= ovr_d;  frm_q <= frm_d;  perr_q <= perr_d;
    end
  end

  // status word assembly
  always_comb begin
    status = 32'h00000000;
    status[SB_RX_READY] = rx_rdy_q & rx_en_q; // R12 R13
    status[SB_TX_READY] = tx_en_q & ~thr_full_q; // R14
    status[SB_RXEND] = rx_dma_end; // R17
    status[SB_TXEND] = tx_dma_end; // R17
    status[SB_OVR]   = ovr_q;
    status[SB_FRM]   = frm_q;
    status[SB_PAR]   = perr_q;
    status[SB_TXEMP] = tx_en_q & ~thr_full_q & ~tx_busy; // R16
    status[SB_TXBE]  = tx_dma_buf_empty; // R18
    status[SB_RXBF]  = rx_dma_buf_full; // R18
    status[SB_DBGW]  = debug_write_pending; // R19
    status[SB_DBGR]  = debug_read_pending; // R19
  end

  // register writes and read data
  always_comb begin
    mode_d = mode_q;  mask_d = mask_q;  baud_d = baud_q;  tap_d = tap_q;
    prdata_d = prdata_q;
    if (wr_en) begin
      case (paddr)
        OFS_MODE:   mode_d = pwdata & MODE_WMASK;
        OFS_IEN:    mask_d = mask_q | (pwdata & IRQ_WMASK); // R9
        OFS_IDIS:   mask_d = mask_q & ~pwdata; // R10
        OFS_BAUD:   baud_d = pwdata[15:0]; // R20
        OFS_TAPRST: tap_d = pwdata[0];
        default:    tap_d = tap_q;
      endcase
    end
    if (psel && !penable && !pwrite) begin
      case (paddr)
        OFS_MODE:   prdata_d = mode_q;
        OFS_IMASK:  prdata_d = mask_q; // R11
        OFS_STAT:   prdata_d = status;
        OFS_RXH:    prdata_d = {24'h000000, rhr_q};
        OFS_BAUD:   prdata_d = {16'h0000, baud_q}; // R20
        OFS_CID:    prdata_d = CHIP_ID_VAL;
        OFS_CIDX:   prdata_d = CHIP_EXT_VAL;
        OFS_TAPRST: prdata_d = {31'h00000000, tap_q};
        default:    prdata_d = 32'h00000000;
      endcase
    end
  end
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      mode_q <= RST_MODE;  mask_q <= RST_MASK;  baud_q <= RST_BAUD;
      tap_q <= 1'b0;  prdata_q <= 32'h00000000;
    end else begin
      mode_q <= mode_d;  mask_q <= mask_d;  baud_q <= baud_d;
      tap_q <= tap_d;  prdata_q <= prdata_d;
    end
  end
  assign prdata = prdata_q;
  assign irq    = |(status & mask_q); // R26

  // checks
  a_irq_gate: assert property (@(posedge clk_sys) disable iff (!rstn)
    irq == |(status & mask_q)) else $error("irq mismatch"); // R26
  a_stclr_errs: assert property (@(posedge clk_sys) disable iff (!rstn)
    cmd_wr && pwdata[CB_STCLR] && !(tick && rst_q == DU_STOP)
    |=> !frm_q && !perr_q) else $error("errors not cleared"); // R7
  a_rxrst_now: assert property (@(posedge clk_sys) disable iff (!rstn)
    cmd_wr && pwdata[CB_RXRST] |=> !rx_en_q && rst_q == DU_IDLE)
    else $error("rx reset slow"); // R1
  a_txrst_now: assert property (@(posedge clk_sys) disable iff (!rstn)
    cmd_wr && pwdata[CB_TXRST] |=> !tx_en_q && !thr_full_q && tline_q)
    else $error("tx reset slow"); // R2
  a_ien_set: assert property (@(posedge clk_sys) disable iff (!rstn)
    wr_en && paddr == OFS_IEN |=> (mask_q & $past(pwdata) & IRQ_WMASK)
    == ($past(pwdata) & IRQ_WMASK)) else $error("mask not set"); // R9
  a_idis_clr: assert property (@(posedge clk_sys) disable iff (!rstn)
    wr_en && paddr == OFS_IDIS |=> (mask_q & $past(pwdata)) == 32'h0)
    else $error("mask not cleared"); // R10
  a_tx_ready_dis: assert property (@(posedge clk_sys) disable iff (!rstn)
    !tx_en_q |-> !status[SB_TX_READY] && !status[SB_TXEMP])
    else $error("tx flags while off"); // R14
  a_rx_enable_cmd_dis: assert property (@(posedge clk_sys) disable iff (!rstn)
    cmd_wr && pwdata[CB_RX_ENABLE_CMD] && pwdata[CB_RX_DISABLE_CMD] && !rx_en_q
    |=> !rx_en_q) else $error("rx enabled despite disable"); // R3
  a_loop_out: assert property (@(posedge clk_sys) disable iff (!rstn)
    chm == CHM_LLOOP |-> serial_out_pin) else $error("pin not idle"); // R24
  a_ovr_sticky: assert property (@(posedge clk_sys) disable iff (!rstn)
    ovr_q && !(cmd_wr && pwdata[CB_STCLR]) |=> ovr_q)
    else $error("overrun dropped"); // R15

endmodule // dbgu_uart

/* tb/dbgu_term.sv */
// Purpose: remote terminal on the two-wire serial line
// Assumes: bit length in clocks is given by the bench
// Notes:   a start bit that does not last is dropped, as in a real uart
`timescale 1ns/1ps
module dbgu_term (
  // clock and frame settings
  input  wire logic        clk_sys,
  input  wire logic [15:0] bit_clks,
  input  wire logic        parity_on,
  // serial line
  input  wire logic        line_in,
  output logic             line_out,
  // received frame as {stop, parity, data}
  output logic             got_q,
  output logic [9:0]       frame_q
);
  logic [9:0] f;
  // send one frame; a faulty parity or stop is given by the caller
  task automatic send(input logic [7:0] d, input logic p, input logic s);
    logic [10:0] b;
    b = {s, p, d, 1'b0};
    for (int i = 0; i < 11; i++) begin
      if (i != 9 || parity_on) begin
        line_out <= b[i];
        repeat (bit_clks) @(posedge clk_sys);
      end
    end
    line_out <= 1'b1;
    // one idle clock, so a following frame never reassigns in this step
    @(posedge clk_sys);
  endtask
  // receive: sample each bit at its middle
  initial begin
    line_out = 1'b1;
    got_q = 1'b0;
    frame_q = 10'h000;
    f = 10'h000;
    forever begin
      @(posedge clk_sys);
      got_q <= 1'b0;
      if (line_in === 1'b0) begin
        repeat (bit_clks / 2) @(posedge clk_sys);
        if (line_in === 1'b0) begin
          for (int i = 0; i < 10; i++) begin
            f[i] = 1'b0;
            if (i != 8 || parity_on) begin
              repeat (bit_clks) @(posedge clk_sys);
              f[i] = line_in;
            end
          end
          got_q <= 1'b1;
          frame_q <= f;
        end
      end
    end
  end
endmodule // dbgu_term

/* tb/tb_dbgu_uart.sv */
// Purpose: self-checking bench for the debug uart block
// Assumes: divisor 1 gives 16 clocks a bit, divisor 2 gives 32
// Notes:   reads and frames are matched against queues of notes
`timescale 1ns/1ps
module tb_dbgu_uart
  import dbgu_pkg::*;
;
  typedef struct packed {
    logic [31:0] v;
    logic [31:0] m;
  } dbgu_exp_s;
  localparam logic [31:0] ALL      = 32'hFFFFFFFF;
  localparam logic [31:0] C_RX_RST = 32'h1 << CB_RXRST;
  localparam logic [31:0] C_TX_RST = 32'h1 << CB_TXRST;
  localparam logic [31:0] C_RX_ON  = 32'h1 << CB_RX_ENABLE_CMD;
  localparam logic [31:0] C_RX_OFF = 32'h1 << CB_RX_DISABLE_CMD;
  localparam logic [31:0] C_TX_ON  = 32'h1 << CB_TX_ENABLE_CMD;
  localparam logic [31:0] C_TX_OFF = 32'h1 << CB_TX_DISABLE_CMD;
  localparam logic [31:0] C_ST_CLR = 32'h1 << CB_STCLR;
  logic        clk_sys, rstn, psel, penable, pwrite, pready, pslverr;
  logic        irq, sin, sout, got, parity_on, hold_hi, p;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [5:0]  side;
  logic [9:0]  frame;
  logic [15:0] bclk;
  logic [7:0]  c;
  integer      seed;
  int          n_errors = 0;
  int          samples_checked = 0;
  dbgu_exp_s   rq[$];
  logic [9:0]  sq[$];

  // 200 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  dbgu_uart dbgu_uart_inst (
    .clk_sys(clk_sys), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rx_dma_end(side[0]),
    .tx_dma_end(side[1]), .tx_dma_buf_empty(side[2]),
    .rx_dma_buf_full(side[3]), .debug_write_pending(side[4]),
    .debug_read_pending(side[5]), .serial_in_pin(sin),
    .serial_out_pin(sout), .irq(irq));

  dbgu_term dbgu_term_inst (
    .clk_sys(clk_sys), .bit_clks(bclk), .parity_on(parity_on),
    .line_in(sout), .line_out(sin), .got_q(got), .frame_q(frame));

  task automatic check(input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      n_errors++;
      $display("Error %0t: saw %h expected %h", $time, s, e);
    end
  endtask

  task automatic finish_test();
    if (n_errors == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // one apb transfer, then an idle cycle so strobes never toggle twice
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    for (int i = 0; i < 100 && pready !== 1'b1; i++) @(posedge clk_sys);
    if (pready !== 1'b1) n_errors++;
    r = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    apb(1'b1, a, d, r);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] e,
                    input logic [31:0] m);
    logic [31:0] r;
    rq.push_back('{e, m});
    apb(1'b0, a, 32'h0, r);
  endtask

  // status = uart bits plus the mirrored side inputs
  function automatic logic [31:0] sd(input logic [31:0] u);
    return u | {side[5], side[4], 17'h0, side[3], side[2], 6'h0,
                side[1], side[0], 3'h0};
  endfunction

  task automatic rs(input logic [31:0] u);
    rd(OFS_STAT, sd(u), ALL);
  endtask

  // poll until the transmitter is empty; polls are not compared
  task automatic idle();
    logic [31:0] r;
    r = 32'h0;
    for (int i = 0; i < 300 && r[SB_TXEMP] !== 1'b1; i++) begin
      rq.push_back('{32'h0, 32'h0});
      apb(1'b0, OFS_STAT, 32'h0, r);
    end
    check({31'h0, r[SB_TXEMP]}, 32'h1);
  endtask

  task automatic wq();
    for (int i = 0; i < 3000 && sq.size() != 0; i++) @(posedge clk_sys);
    check(32'(sq.size()), 32'h0);
  endtask

  // terminal sends with even parity, optionally spoilt
  task automatic snd(input logic [7:0] d, input logic bad, input logic s);
    dbgu_term_inst.send(d, ^d ^ bad, s);
  endtask

  // command issued 60 clocks into a character, while it is being received
  task automatic mid(input logic [7:0] d, input logic [31:0] cmd);
    fork
      snd(d, 1'b0, 1'b1);
      begin
        repeat (60) @(posedge clk_sys);
        wr(OFS_CTRL, cmd);
      end
    join
  endtask

  // watcher: oldest note against each read, frame and held line
  always @(posedge clk_sys) begin
    if (psel && penable && !pwrite && pready && rq.size() != 0) begin
      if (rq[0].m != 32'h0)
        check(prdata & rq[0].m, rq[0].v & rq[0].m);
      void'(rq.pop_front());
    end
    if (got === 1'b1)
      check({22'h0, frame},
            {22'h0, sq.size() != 0 ? sq.pop_front() : 10'h0});
    if (hold_hi) check({31'h0, sout}, 32'h1);
    if (psel && penable) check({30'h0, pready, pslverr}, 32'h2);
  end

  // hang guard, far above the expected run length
  initial begin
    repeat (40000) @(posedge clk_sys);
    n_errors++;
    finish_test();
  end

  // main sequence
  initial begin
    seed = 32'h0000B4A3;
    rstn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    side = 6'h00;
    hold_hi = 1'b0;
    bclk = 16'h0010;
    parity_on = 1'b1;
    repeat (2) @(posedge clk_sys);
    rstn <= 1'b1;
    side <= 6'($random(seed));
    @(posedge clk_sys);
    rd(OFS_MODE, RST_MODE, ALL);
    rd(OFS_IMASK, RST_MASK, ALL);
    rd(OFS_BAUD, 32'h0, ALL);
    rd(12'h024, 32'h0, ALL);
    rs(32'h0);
    wr(OFS_MODE, ALL);
    wr(OFS_IMASK, ALL);
    wr(OFS_BAUD, ALL);
    rd(OFS_MODE, MODE_WMASK, ALL);
    rd(OFS_IMASK, RST_MASK, ALL);
    rd(OFS_BAUD, 32'h0000FFFF, ALL);
    wr(OFS_IEN, ALL);
    rd(OFS_IMASK, IRQ_WMASK, ALL);
    wr(OFS_IDIS, 32'h0000000F);
    rd(OFS_IMASK, IRQ_WMASK & 32'hFFFFFFF0, ALL);
    check({31'h0, irq}, {31'h0, |(sd(32'h0) & IRQ_WMASK & 32'hFFFFFFF0)});
    wr(OFS_IDIS, ALL);
    side <= 6'h10;
    wr(OFS_IEN, 32'h1 << SB_DBGW);
    check({31'h0, irq}, 32'h1);
    wr(OFS_IDIS, 32'h1 << SB_DBGW);
    check({31'h0, irq}, 32'h0);
    side <= 6'($random(seed));
    // transmitter: enable rules, every parity code
    wr(OFS_MODE, 32'h0);
    wr(OFS_BAUD, 32'h1);
    wr(OFS_CTRL, C_TX_ON | C_TX_OFF);
    rs(32'h0);
    wr(OFS_CTRL, C_TX_ON);
    rs(32'h202);
    for (int k = 0; k < 5; k++) begin
      c = 8'($random(seed));
      p = (k == 0) ? ^c : (k == 1) ? ~^c : (k == 3);
      wr(OFS_MODE, 32'(k) << MF_PAR_LO);
      parity_on <= (k < 4);
      sq.push_back({1'b1, p, c});
      wr(OFS_TXH, {24'h0, c});
      idle();
    end
    sq.push_back(10'h211);
    sq.push_back(10'h222);
    wr(OFS_TXH, 32'h11);
    wr(OFS_TXH, 32'h22);
    rs(32'h0);
    wr(OFS_CTRL, C_TX_OFF);
    wq();
    repeat (20) @(posedge clk_sys); // stop bit still runs after mid sample
    rs(32'h0);
    // reset the transmitter inside the start bit
    wr(OFS_CTRL, C_TX_ON);
    wr(OFS_TXH, 32'h55);
    for (int i = 0; i < 50 && sout !== 1'b0; i++) @(posedge clk_sys);
    wr(OFS_CTRL, C_TX_RST);
    hold_hi <= 1'b1;
    repeat (200) @(posedge clk_sys);
    hold_hi <= 1'b0;
    rs(32'h0);
    // divisor 0 holds the line, divisor 2 gives 32 clocks a bit
    wr(OFS_BAUD, 32'h0);
    wr(OFS_CTRL, C_TX_ON);
    wr(OFS_TXH, 32'hA7);
    hold_hi <= 1'b1;
    repeat (200) @(posedge clk_sys);
    hold_hi <= 1'b0;
    bclk <= 16'h0020;
    sq.push_back(10'h2A7);
    wr(OFS_BAUD, 32'h2);
    wq();
    idle();
    wr(OFS_BAUD, 32'h1);
    bclk <= 16'h0010;
    // receiver: enable, ready, overrun and sticky errors
    wr(OFS_MODE, 32'h0);
    parity_on <= 1'b1;
    wr(OFS_CTRL, C_RX_ON | C_RX_OFF);
    snd(8'h96, 1'b0, 1'b1);
    rs(32'h202);
    wr(OFS_CTRL, C_RX_ON);
    snd(8'h96, 1'b0, 1'b1);
    rs(32'h203);
    rd(OFS_RXH, 32'h96, ALL);
    rs(32'h202);
    snd(8'h01, 1'b0, 1'b1);
    snd(8'h02, 1'b0, 1'b1);
    rs(32'h223);
    snd(8'h03, 1'b1, 1'b1);
    rs(32'h2A3);
    snd(8'h04, 1'b0, 1'b0);
    repeat (200) @(posedge clk_sys);
    rs(32'h2E3);
    snd(8'h05, 1'b0, 1'b1);
    rs(32'h2E3);
    wr(OFS_CTRL, C_ST_CLR);
    rs(32'h203);
    rd(OFS_RXH, 32'h05, ALL);
    mid(8'h3E, C_RX_OFF);
    rd(OFS_RXH, 32'h3E, ALL);
    rs(32'h202);
    wr(OFS_CTRL, C_RX_ON);
    mid(8'hC3, C_RX_RST);
    wr(OFS_CTRL, C_RX_ON);
    rs(32'h202);
    // channel modes: local loopback, echo, remote loopback
    wr(OFS_MODE, {16'h0, CHM_LLOOP, 14'h0});
    hold_hi <= 1'b1;
    wr(OFS_TXH, 32'h81);
    idle();
    hold_hi <= 1'b0;
    rd(OFS_RXH, 32'h81, ALL);
    for (int k = 1; k < 4; k += 2) begin
      wr(OFS_MODE, 32'(k) << MF_CHM_LO);
      c = 8'($random(seed));
      sq.push_back({1'b1, ^c, c});
      snd(c, 1'b0, 1'b1);
      wq();
      if (k == 1) rd(OFS_RXH, {24'h0, c}, ALL);
    end
    rd(OFS_STAT, 32'h0, 32'h1 << SB_RX_READY);
    finish_test();
  end
endmodule // tb_dbgu_uart
